// ==== rtl/psp_protect.sv ====
/*
 * Protection and sequencing control for a four half-bridge power stage.
 * Assumes supply-good, short and event inputs come from analog comparators
 * asynchronous to clk_i; software holds mode, package and filter size.
 */
`timescale 1ns/1ns
module psp_protect #(
    parameter int unsigned CHECK_CYC_PER_UF = psp_pkg::CHECK_CYC_PER_UF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        logic_supply_ok_i,
    input  wire logic        gate_drive_supply_ok_i,
    input  wire logic        reset_n_i,
    input  wire logic        short_gnd_i,
    input  wire logic        short_supply_i,
    input  wire logic        overload_i,
    input  wire logic        overcurrent_i,
    input  wire logic        clip_i,
    input  wire logic [7:0]  temp_i,
    output logic             bridge_enable_o,
    output logic             weak_pulldown_o,
    output logic             check_drive_o,
    output logic             fault_shutdown_n_o,
    output logic             fault_shutdown_n_oe_o,
    output logic             temp_warning_lower_n_o,
    output logic             temp_warning_lower_n_oe_o,
    output logic             temp_warning_upper_n_o,
    output logic             temp_warning_upper_n_oe_o,
    output logic             ready_o,
    output logic             clip_o
);
    import psp_pkg::*;

    // Two-flop synchronisers for the asynchronous inputs
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [7:0]       temp_a;
    logic [7:0]       temp_b;
    logic [7:0]       temp_c;
    logic [7:0]       temp_s;
    always_ff @(posedge clk_i) begin
        sync_a <= {logic_supply_ok_i, gate_drive_supply_ok_i, reset_n_i, short_gnd_i,
                   short_supply_i, overload_i, overcurrent_i, clip_i};
        sync_b <= sync_a;
        temp_a <= temp_i;
        temp_b <= temp_a;
        temp_c <= temp_b;
    end
    // Temperature word is taken only once two synchronised samples agree
    always_ff @(posedge clk_i) begin
        if (temp_b == temp_c) begin
            temp_s <= temp_c;
        end
    end
    logic sup_ok, rst_n_s, sh_gnd, sh_sup, ovl, ocur, clip_s;
    assign sup_ok  = sync_b[7] & sync_b[6];
    assign rst_n_s = sync_b[5];
    assign sh_gnd  = sync_b[4];
    assign sh_sup  = sync_b[3];
    assign ovl     = sync_b[2];
    assign ocur    = sync_b[1];
    assign clip_s  = sync_b[0];

    // Register file
    logic [31:0] ctrl;
    psp_mode_t   mode;
    logic        small_pkg;
    logic [7:0]  cap_uf;
    assign mode      = psp_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
    assign small_pkg = ctrl[CTRL_PKG_BIT];
    assign cap_uf    = ctrl[CTRL_CAP_LSB +: 8];

    logic req;
    logic hit;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit = (wb_adr_i == REG_CTRL) || (wb_adr_i == REG_STATUS) || (wb_adr_i == REG_TEMP);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
        end else if (req && wb_we_i && wb_adr_i == REG_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    ctrl[8*i +: 8] <= wb_dat_i[8*i +: 8];
                end
            end
        end
    end

    psp_state_t  state;
    logic        therm_latch;
    logic        ovl_latch;
    logic        warn_low, warn_high;
    logic [31:0] status_word;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            case (wb_adr_i)
                REG_CTRL:   wb_dat_o <= ctrl;
                REG_STATUS: wb_dat_o <= status_word;
                REG_TEMP:   wb_dat_o <= {24'h00_0000, temp_s};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Thermal levels
    always_comb begin
        warn_low  = ~small_pkg && (temp_s > TEMP_WARN_LOW);
        warn_high = temp_s > TEMP_WARN_HIGH;
    end

    // Reset-pin rising edge; ignored while the short check runs
    logic rst_n_d;
    logic rst_rise;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_n_d <= 1'b1;
        end else begin
            rst_n_d <= rst_n_s;
        end
    end
    assign rst_rise = rst_n_s & ~rst_n_d;

    // Short check timer: length = filter capacitance times half the per-uF budget
    logic [39:0] chk_cnt;
    logic [39:0] chk_len;
    logic        chk_done;
    assign chk_len  = 40'(cap_uf) * 40'(CHECK_CYC_PER_UF) / 40'd2;
    assign chk_done = (chk_cnt >= chk_len);

    logic in_check;
    assign in_check = (state == ST_CHECK_GND) || (state == ST_CHECK_SUPPLY)
                   || (state == ST_SHORT_HOLD);

    // Startup sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= ST_POWER_OFF;
            chk_cnt <= 40'd0;
        end else if (!sup_ok) begin
            state   <= ST_POWER_OFF;
            chk_cnt <= 40'd0;
        end else begin
            case (state)
                ST_POWER_OFF: begin
                    chk_cnt <= 40'd0;
                    if (mode == PSP_SINGLE) begin
                        state <= ST_WAIT_RESET;
                    end else begin
                        state <= ST_CHECK_GND;
                    end
                end
                ST_CHECK_GND: begin
                    if (sh_gnd) begin
                        state <= ST_SHORT_HOLD;
                    end else if (chk_done) begin
                        state   <= ST_CHECK_SUPPLY;
                        chk_cnt <= 40'd0;
                    end else begin
                        chk_cnt <= chk_cnt + 40'd1;
                    end
                end
                ST_CHECK_SUPPLY: begin
                    if (sh_sup) begin
                        state <= ST_SHORT_HOLD;
                    end else if (chk_done) begin
                        state <= ST_WAIT_RESET;
                    end else begin
                        chk_cnt <= chk_cnt + 40'd1;
                    end
                end
                ST_SHORT_HOLD: begin
                    chk_cnt <= 40'd0;
                    if (!sh_gnd && !sh_sup) begin
                        state <= ST_CHECK_GND;
                    end
                end
                ST_WAIT_RESET: begin
                    if (rst_n_s) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!rst_n_s) begin
                        state <= ST_WAIT_RESET;
                    end
                end
                default: state <= ST_POWER_OFF;
            endcase
        end
    end

    // Latched thermal shutdown and overload; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i || !sup_ok) begin
            therm_latch <= 1'b0;
            ovl_latch   <= 1'b0;
        end else begin
            if (temp_s > TEMP_SHUTDOWN) begin
                therm_latch <= 1'b1;
            end else if (!in_check && !rst_n_s) begin
                therm_latch <= 1'b0;
            end
            if (ovl && state == ST_RUN) begin
                ovl_latch <= 1'b1;
            end else if (!in_check && rst_rise) begin
                ovl_latch <= 1'b0;
            end
        end
    end

    // Output drive
    logic fault;
    logic fault_out_low;
    assign fault = therm_latch | ovl_latch | ~sup_ok;
    always_comb begin
        if (in_check) begin
            fault_out_low = 1'b1;
        end else if (!rst_n_s) begin
            fault_out_low = 1'b0;
        end else begin
            fault_out_low = fault | (state != ST_RUN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bridge_enable_o           <= 1'b0;
            weak_pulldown_o           <= 1'b0;
            check_drive_o             <= 1'b0;
            fault_shutdown_n_oe_o     <= 1'b1;
            temp_warning_lower_n_oe_o <= 1'b0;
            temp_warning_upper_n_oe_o <= 1'b0;
            ready_o                   <= 1'b0;
            clip_o                    <= 1'b0;
        end else begin
            bridge_enable_o <= (state == ST_RUN) && !fault && rst_n_s;
            weak_pulldown_o <= !rst_n_s && sup_ok && !in_check
                               && (mode != PSP_SINGLE);
            check_drive_o   <= (state == ST_CHECK_GND) || (state == ST_CHECK_SUPPLY);
            fault_shutdown_n_oe_o     <= fault_out_low;
            temp_warning_lower_n_oe_o <= warn_low;
            temp_warning_upper_n_oe_o <= warn_high;
            ready_o <= (state == ST_RUN) && !fault && !ocur && rst_n_s;
            clip_o  <= clip_s && (state == ST_RUN);
        end
    end
    // Open-drain pins drive only low
    assign fault_shutdown_n_o     = 1'b0;
    assign temp_warning_lower_n_o = 1'b0;
    assign temp_warning_upper_n_o = 1'b0;

    assign status_word = {22'h00_0000, clip_o, ready_o, ovl_latch, therm_latch,
                          warn_high, warn_low, sup_ok, 3'(state)};

    // Checks
    check_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_check |=> fault_shutdown_n_oe_o)
        else $error("fault not held low during short check");
    short_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_SHORT_HOLD |=> !bridge_enable_o)
        else $error("bridges enabled while short present");
    single_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_POWER_OFF && sup_ok && mode == PSP_SINGLE |=> state == ST_WAIT_RESET)
        else $error("check not skipped in single-ended mode");
    reset_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_n_s |=> !bridge_enable_o)
        else $error("bridges enabled while reset low");
    therm_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        therm_latch && rst_n_s && sup_ok |=> therm_latch)
        else $error("thermal latch dropped without reset");
    uv_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sup_ok |=> !bridge_enable_o && (fault_shutdown_n_oe_o || !$past(rst_n_s)))
        else $error("undervoltage not shut down");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_n_s && !in_check |=> !fault_shutdown_n_oe_o)
        else $error("fault shown while reset low");
    ready_ocur_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ocur |=> !ready_o)
        else $error("ready high during overcurrent");
    no_recheck_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_RUN && sup_ok |=> state != ST_CHECK_GND)
        else $error("reset restarted the short check");
    check_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state != ST_CHECK_SUPPLY ##1 state == ST_CHECK_SUPPLY |-> $past(state) == ST_CHECK_GND)
        else $error("supply step entered without ground step");
    therm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        therm_latch && rst_n_s |=> !bridge_enable_o && fault_shutdown_n_oe_o)
        else $error("thermal shutdown not applied");
    se_no_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == PSP_SINGLE |=> !weak_pulldown_o)
        else $error("pulldown enabled in single-ended mode");
endmodule

// ==== rtl/psp_pkg.sv ====
/*
 * Constants and types for the power stage protection controller.
 * Assumes a 250 MHz system clock and classic Wishbone register access.
 */
package psp_pkg;

    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned CHECK_MS_PER_UF  = 15;
    localparam int unsigned RESET_GAP_MS     = 4;
    localparam int unsigned CHECK_CYC_PER_UF = CHECK_MS_PER_UF * CLK_MHZ * 1000;
    localparam int unsigned RESET_GAP_CYC    = RESET_GAP_MS * CLK_MHZ * 1000;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TEMP   = 8'h08;

    // Control field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_PKG_BIT  = 2;
    localparam int unsigned CTRL_CAP_LSB  = 8;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

    // Temperature thresholds, degrees C
    localparam logic [7:0] TEMP_WARN_LOW  = 8'd100;
    localparam logic [7:0] TEMP_WARN_HIGH = 8'd125;
    localparam logic [7:0] TEMP_SHUTDOWN  = 8'd155;

    typedef enum logic [1:0] {
        PSP_BRIDGE   = 2'd0,
        PSP_PARALLEL = 2'd1,
        PSP_SINGLE   = 2'd2
    } psp_mode_t;

    typedef enum logic [2:0] {
        ST_POWER_OFF,
        ST_CHECK_GND,
        ST_CHECK_SUPPLY,
        ST_SHORT_HOLD,
        ST_WAIT_RESET,
        ST_RUN
    } psp_state_t;

endpackage

// ==== tb/psp_ctrl_model.sv ====
/*
 * Model of the controller that drives the device reset pin.
 * Assumes pins arrive already resolved, with pull-ups, as active-low levels.
 */
`timescale 1ns/1ns
module psp_ctrl_model #(
    parameter int unsigned GAP_CYC = 40
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hold_low_i,
    input  wire logic fault_shutdown_n_i,
    input  wire logic temp_warning_lower_n_i,
    input  wire logic temp_warning_upper_n_i,
    output logic      reset_n_o
);
    logic        fault_q;
    int unsigned since_fall;
    // Cycles since the fault pin last fell
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
            since_fall <= 0;
        end else begin
            fault_q <= fault_shutdown_n_i;
            if (fault_q && !fault_shutdown_n_i)
                since_fall <= 0;
            else if (since_fall < GAP_CYC)
                since_fall <= since_fall + 1;
        end
    end
    // Release reset only after the gap and with every warning gone
    always_ff @(posedge clk_i) begin
        if (rst_i || hold_low_i)
            reset_n_o <= 1'b0;
        else if (since_fall >= GAP_CYC && temp_warning_lower_n_i && temp_warning_upper_n_i)
            reset_n_o <= 1'b1;
    end
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the protection controller.
 * Assumes a short check of CYC_UF cycles per uF and a reset-pin controller model.
 */
`timescale 1ns/1ns
module tb_top;
    import psp_pkg::*;
    localparam int unsigned CYC_UF = 20;
    localparam int unsigned GAP    = 40;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, temp_i = 8'h19, t;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic        logic_supply_ok_i = 1'b0, gate_drive_supply_ok_i = 1'b0, short_gnd_i = 1'b0;
    logic        short_supply_i = 1'b0, overload_i = 1'b0, overcurrent_i = 1'b0, clip_i = 1'b0;
    logic        hold_low = 1'b1, oc, cl, reset_n_i, wb_ack_o, wb_err_o, bridge_enable_o;
    logic        weak_pulldown_o, check_drive_o, fault_shutdown_n_o, fault_shutdown_n_oe_o;
    logic        ready_o, clip_o, temp_warning_lower_n_o, temp_warning_lower_n_oe_o;
    logic        temp_warning_upper_n_o, temp_warning_upper_n_oe_o;
    logic [7:0]  corner [5];
    int          mismatches = 0, n_compared = 0, cycles = 0;
    wire fault_n   = fault_shutdown_n_oe_o ? fault_shutdown_n_o : 1'b1;
    wire warn_lo_n = temp_warning_lower_n_oe_o ? temp_warning_lower_n_o : 1'b1;
    wire warn_hi_n = temp_warning_upper_n_oe_o ? temp_warning_upper_n_o : 1'b1;

    psp_protect #(.CHECK_CYC_PER_UF(CYC_UF)) dut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .logic_supply_ok_i, .gate_drive_supply_ok_i,
        .reset_n_i, .short_gnd_i, .short_supply_i, .overload_i, .overcurrent_i, .clip_i,
        .temp_i, .bridge_enable_o, .weak_pulldown_o, .check_drive_o, .fault_shutdown_n_o,
        .fault_shutdown_n_oe_o, .temp_warning_lower_n_o, .temp_warning_lower_n_oe_o,
        .temp_warning_upper_n_o, .temp_warning_upper_n_oe_o, .ready_o, .clip_o);
    psp_ctrl_model #(.GAP_CYC(GAP)) ctrl (
        .clk_i, .rst_i, .hold_low_i(hold_low), .fault_shutdown_n_i(fault_n),
        .temp_warning_lower_n_i(warn_lo_n), .temp_warning_upper_n_i(warn_hi_n),
        .reset_n_o(reset_n_i));

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic warn(input logic [7:0] v, input logic [7:0] lim, input logic en);
        return en && (v > lim);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        chk_bit(n == 1, 1'b1);
    endtask
    task automatic reg_chk(input logic [7:0] adr, input logic xe, input logic [31:0] m,
                           input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        wb(1'b0, adr, 32'h0000_0000, q, e);
        chk_bit(e, xe);
        if (!xe)
            chk_word(q & m, exp);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        logic        e;
        wb(1'b1, adr, dat, q, e);
        chk_bit(e, 1'b0);
    endtask
    task automatic pulse_reset;
        hold_low <= 1'b1;
        tick(5);
        chk_bit(fault_shutdown_n_oe_o, 1'b0);
        chk_bit(bridge_enable_o, 1'b0);
        hold_low <= 1'b0;
        tick(GAP + 10);
    endtask

    initial begin
        corner = '{TEMP_WARN_LOW, TEMP_WARN_LOW + 8'h01, TEMP_WARN_HIGH,
                   TEMP_WARN_HIGH + 8'h01, TEMP_SHUTDOWN};
        void'($urandom(67));
        tick(12);
        rst_i <= 1'b0;
        tick(2);
        chk_bit(bridge_enable_o, 1'b0);
        chk_bit(fault_shutdown_n_oe_o, 1'b0);
        reg_chk(REG_CTRL, 1'b0, 32'hFFFF_FFFF, CTRL_RESET);
        reg_chk(8'hFC, 1'b1, 32'h0000_0000, 32'h0000_0000);
        reg_chk(REG_STATUS, 1'b0, 32'h0000_0087, 32'h0000_0000);
        logic_supply_ok_i <= 1'b1;
        gate_drive_supply_ok_i <= 1'b1;
        tick(6);
        chk_bit(check_drive_o, 1'b1);
        chk_bit(fault_shutdown_n_oe_o, 1'b1);
        reg_chk(REG_STATUS, 1'b0, 32'h0000_0007, 32'h0000_0001);
        tick(8);
        reg_chk(REG_STATUS, 1'b0, 32'h0000_0007, 32'h0000_0002);
        tick(12);
        chk_bit(weak_pulldown_o, 1'b1);
        chk_bit(fault_shutdown_n_oe_o, 1'b0);
        hold_low <= 1'b0;
        tick(GAP + 10);
        chk_bit(bridge_enable_o, 1'b1);
        chk_bit(fault_shutdown_n_oe_o, 1'b0);
        chk_bit(ready_o, 1'b1);
        pulse_reset();
        reg_chk(REG_STATUS, 1'b0, 32'h0000_0007, 32'h0000_0005);
        for (int p = 0; p < 2; p++) begin
            wr(REG_CTRL, 32'h0000_0100 | 32'(p << 2));
            for (int i = 0; i < 12; i++) begin
                t = (i < 5) ? corner[i] : 8'($urandom_range(155));
                temp_i <= t;
                tick(6);
                chk_bit(temp_warning_lower_n_oe_o, warn(t, TEMP_WARN_LOW, p == 0));
                chk_bit(temp_warning_upper_n_oe_o, warn(t, TEMP_WARN_HIGH, 1'b1));
                chk_bit(bridge_enable_o, 1'b1);
            end
            reg_chk(REG_TEMP, 1'b0, 32'h0000_00FF, {24'h00_0000, t});
        end
        temp_i <= TEMP_SHUTDOWN + 8'h01;
        tick(7);
        chk_bit(bridge_enable_o, 1'b0);
        chk_bit(fault_shutdown_n_oe_o, 1'b1);
        temp_i <= 8'h28;
        tick(5);
        chk_bit(bridge_enable_o, 1'b0);
        pulse_reset();
        chk_bit(bridge_enable_o, 1'b1);
        overload_i <= 1'b1;
        tick(5);
        overload_i <= 1'b0;
        chk_bit(fault_shutdown_n_oe_o, 1'b1);
        tick(5);
        chk_bit(bridge_enable_o, 1'b0);
        pulse_reset();
        chk_bit(bridge_enable_o, 1'b1);
        for (int i = 0; i < 8; i++) begin
            oc = (i < 2) ? i[0] : 1'($urandom_range(1));
            cl = (i < 2) ? !i[0] : 1'($urandom_range(1));
            overcurrent_i <= oc;
            clip_i <= cl;
            tick(5);
            chk_bit(ready_o, !oc);
            chk_bit(clip_o, cl);
        end
        overcurrent_i <= 1'b0;
        clip_i <= 1'b0;
        wr(REG_CTRL, 32'h0000_0101);
        short_supply_i <= 1'b1;
        tick(5);
        chk_bit(bridge_enable_o, 1'b1);
        gate_drive_supply_ok_i <= 1'b0;
        tick(5);
        chk_bit(bridge_enable_o, 1'b0);
        chk_bit(fault_shutdown_n_oe_o, 1'b1);
        gate_drive_supply_ok_i <= 1'b1;
        tick(20);
        reg_chk(REG_STATUS, 1'b0, 32'h0000_0007, 32'h0000_0003);
        chk_bit(bridge_enable_o, 1'b0);
        short_supply_i <= 1'b0;
        tick(40);
        chk_bit(bridge_enable_o, 1'b1);
        wr(REG_CTRL, 32'h0000_0102);
        logic_supply_ok_i <= 1'b0;
        tick(5);
        logic_supply_ok_i <= 1'b1;
        tick(8);
        chk_bit(check_drive_o, 1'b0);
        chk_bit(bridge_enable_o, 1'b1);
        hold_low <= 1'b1;
        tick(5);
        chk_bit(weak_pulldown_o, 1'b0);
        hold_low <= 1'b0;
        tick(GAP + 10);
        chk_bit(bridge_enable_o, 1'b1);
        final_report();
    end
endmodule
